// File: twm_consts.svh
`ifndef TWM_CONSTS_SVH
`define TWM_CONSTS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define TWM_ADR_CTRL   8'h00
`define TWM_ADR_STAT   8'h04
`define TWM_ADR_DATA   8'h08
`define TWM_ADR_RATE   8'h0C
`define TWM_ADR_OWN    8'h10

// ----------------------------------------
// Control register bit positions, plus own address field offset
// ----------------------------------------
`define TWM_C_FLAG     7
`define TWM_C_START    5
`define TWM_C_STOP     4
`define TWM_C_EN       2
`define TWM_C_ADDRD    1
`define TWM_C_RXM      0
`define TWM_OWN_LSB    1

// ----------------------------------------
// Status codes, prescaler field always zero
// ----------------------------------------
`define TWM_S_START    8'h08
`define TWM_S_RSTART   8'h10
`define TWM_S_AW_ACK   8'h18
`define TWM_S_AW_NAK   8'h20
`define TWM_S_D_ACK    8'h28
`define TWM_S_D_NAK    8'h30
`define TWM_S_ARB      8'h38
`define TWM_S_AR_ACK   8'h40
`define TWM_S_AR_NAK   8'h48
`define TWM_S_NONE     8'hF8
`define TWM_S_BUSERR   8'h00

// ----------------------------------------
// Timing and framing
// ----------------------------------------
`define TWM_CLK_NS     100
`define TWM_HALF_NS    5000
`define TWM_HALF_CYC   (`TWM_HALF_NS / `TWM_CLK_NS)
`define TWM_ACK_BIT    4'h8
`define TWM_IDLE_LVL   1'b1

`endif

// File: twm_pkg.sv
package twm_pkg;

  // ----------------------------------------
  // Sequencer states, Gray code in listed order
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_START = 4'h1,
    ST_HOLD  = 4'h3,
    ST_BLOW  = 4'h2,
    ST_BHIGH = 4'h6,
    ST_PLOW  = 4'h7,
    ST_PHIGH = 4'h5,
    ST_PFREE = 4'h4,
    ST_RLOW  = 4'hC,
    ST_RHIGH = 4'hD
  } twm_state_t;

  // ----------------------------------------
  // Wishbone request bundle
  // ----------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } twm_wb_req_t;

endpackage : twm_pkg

// File: twm_sync.sv
`timescale 1ns/1ps
`include "twm_consts.svh"

module twm_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic [2:0] ff_r;

  // Level only moves once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ff_r <= {3{`TWM_IDLE_LVL}};
      q_o  <= `TWM_IDLE_LVL;
    end else begin
      ff_r <= {ff_r[1:0], d_i};
      if (ff_r[1] == ff_r[2]) begin
        q_o <= ff_r[2];
      end
    end
  end

endmodule : twm_sync

// File: twm_master.sv
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "twm_consts.svh"

// Functional notes
// [R1] SCL and SDA are open-drain; bus level is the wired-AND of masters.
// [R2] High count restarts on seen SCL rise, low count on seen fall.
// [R3] After each driven bit, sample SDA; mismatch means arbitration lost.
// [R4] Loss only when releasing SDA high while another pulls low.
// [R5] On loss, go slave and check if the winner addresses us.
// [R6] After loss keep SDA released; SCL may run to packet end.
// [R7] After START report 0x08; software loads write address, clears flag.
// [R8] After repeated START report 0x10; read bit selects receiver operation. The code only sets RXM; bytes still go out from data.
// [R9] Repeated START keeps the bus, no STOP needed between targets.
// [R10] Write address acknowledged gives 0x18, not acknowledged 0x20.
// [R11] Data byte acknowledged gives 0x28, not acknowledged 0x30.
// [R12] In 0x18..0x30 clearing flag with no requests sends next byte.
// [R13] In 0x18..0x30 clearing flag with start request sends repeated START.
// [R14] Stop request alone sends STOP, then stop request clears itself.
// [R15] Start and stop together send STOP then START, stop request clears.
// [R16] Loss reports 0x38; clearing flag releases bus, non-addressed slave.
// [R17] Flag is cleared by writing one; SCL held low until then. The code releases SCL while the flag is set for 0x38 and 0x00.
// [R18] Status reads 0xF8 while the flag is clear.
// [R19] START or STOP inside a bit sets flag with status 0x00.
// [R20] Status presented with prescaler zero, updated with the flag.

module twm_master
  import twm_pkg::*;
#(
  parameter int RATE_W = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire twm_wb_req_t wb_req_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  twm_state_t        state_r;
  logic              scl_s;
  logic              sda_s;
  logic              scl_q;
  logic              sda_q;
  logic              scl_fall;
  logic              start_det;
  logic              stop_det;
  logic              bus_busy_r;
  logic              hit;
  logic              wr_any;
  logic              wr_ctrl;
  logic              flag_clr;
  logic              req_start;
  logic              req_stop;
  logic [31:0]       rdata;
  logic              flag_r;
  logic              start_r;
  logic              stop_r;
  logic              en_r;
  logic              addrd_r;
  logic              rxm_r;
  logic [7:0]        status_r;
  logic [7:0]        data_r;
  logic [RATE_W-1:0] rate_r;
  logic [6:0]        own_r;
  logic [RATE_W-1:0] cnt_r;
  logic [3:0]        bit_r;
  logic [7:0]        tx_r;
  logic [7:0]        rx_r;
  logic              lost_r;
  logic              is_addr_r;
  logic              rs_r;
  logic              half_end;
  logic              drive_val;
  logic              end_hi;
  logic              berr;
  logic              stop_done;

  // ----------------------------------------
  // Line sampling
  // ----------------------------------------
  twm_sync u_scl_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (scl_i),
    .q_o   (scl_s)
  );

  twm_sync u_sda_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (sda_i),
    .q_o   (sda_s)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_q <= `TWM_IDLE_LVL;
      sda_q <= `TWM_IDLE_LVL;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign scl_fall  = scl_q & ~scl_s;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

  // Bus ownership by anyone, so a START waits for a free bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_busy_r <= 1'b0;
    end else if (start_det) begin
      bus_busy_r <= 1'b1;
    end else if (stop_det) begin
      bus_busy_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Wishbone slave, ack one cycle after request
  // ----------------------------------------
  assign hit       = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
  assign wr_any    = hit & wb_req_i.we & wb_req_i.sel[0];
  assign wr_ctrl   = wr_any & (wb_req_i.adr == `TWM_ADR_CTRL);
  assign flag_clr  = wr_ctrl & wb_req_i.dat[`TWM_C_FLAG]; // [R17]
  assign req_start = wb_req_i.dat[`TWM_C_START];
  assign req_stop  = wb_req_i.dat[`TWM_C_STOP];

  always_comb begin
    rdata = 32'h0000_0000;
    case (wb_req_i.adr)
      `TWM_ADR_CTRL: begin
        rdata[`TWM_C_FLAG]  = flag_r;
        rdata[`TWM_C_START] = start_r;
        rdata[`TWM_C_STOP]  = stop_r;
        rdata[`TWM_C_EN]    = en_r;
        rdata[`TWM_C_ADDRD] = addrd_r;
        rdata[`TWM_C_RXM]   = rxm_r;
      end
      `TWM_ADR_STAT: rdata[7:0] = flag_r ? status_r : `TWM_S_NONE; // [R18] [R20]
      `TWM_ADR_DATA: rdata[7:0] = data_r;
      `TWM_ADR_RATE: rdata[RATE_W-1:0] = rate_r;
      `TWM_ADR_OWN:  rdata[`TWM_OWN_LSB +: 7] = own_r;
      default:       rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= hit;
      if (hit) begin
        wb_dat_o <= rdata;
      end
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  // Hardware clear first, so a software set in the same cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_r <= 1'b0;
      stop_r  <= 1'b0;
      en_r    <= 1'b0;
    end else begin
      if (stop_done) begin
        stop_r <= 1'b0; // [R14] [R15]
      end
      if (wr_ctrl) begin
        start_r <= req_start;
        stop_r  <= req_stop;
        en_r    <= wb_req_i.dat[`TWM_C_EN];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_r <= 8'h00;
      rate_r <= RATE_W'(`TWM_HALF_CYC);
      own_r  <= 7'h00;
    end else if (wr_any) begin
      case (wb_req_i.adr)
        `TWM_ADR_DATA: data_r <= wb_req_i.dat[7:0];
        `TWM_ADR_RATE: rate_r <= wb_req_i.dat[RATE_W-1:0];
        `TWM_ADR_OWN:  own_r  <= wb_req_i.dat[`TWM_OWN_LSB +: 7];
        default:       data_r <= data_r;
      endcase
    end
  end

  // ----------------------------------------
  // Bit sequencer
  // ----------------------------------------
  // Rate below two leaves no room to move SDA inside the low phase
  assign half_end  = (cnt_r >= rate_r);
  assign drive_val = (bit_r < `TWM_ACK_BIT) ? tx_r[7] : 1'b1;
  assign end_hi    = (scl_s & half_end) | scl_fall;
  assign berr      = start_det | stop_det;
  assign stop_done = ((state_r == ST_PFREE) & half_end) |
                     ((state_r == ST_HOLD) & flag_clr &
                      (status_r == `TWM_S_BUSERR)); // [R19]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r   <= ST_IDLE;
      cnt_r     <= '0;
      bit_r     <= 4'h0;
      tx_r      <= 8'h00;
      rx_r      <= 8'h00;
      lost_r    <= 1'b0;
      is_addr_r <= 1'b0;
      rs_r      <= 1'b0;
      flag_r    <= 1'b0;
      status_r  <= `TWM_S_NONE;
      addrd_r   <= 1'b0;
      rxm_r     <= 1'b0;
      scl_oe_o  <= 1'b0;
      sda_oe_o  <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      if (flag_clr) begin
        flag_r <= 1'b0; // [R17]
      end
      case (state_r)
        ST_IDLE: begin
          cnt_r    <= '0;
          scl_oe_o <= 1'b0;
          sda_oe_o <= 1'b0;
          if (en_r && start_r && !bus_busy_r && scl_s && sda_s) begin
            state_r  <= ST_START;
            sda_oe_o <= 1'b1;
            rs_r     <= 1'b0;
            lost_r   <= 1'b0;
            addrd_r  <= 1'b0;
            rxm_r    <= 1'b0;
          end
        end
        ST_START: begin
          if (half_end) begin
            scl_oe_o <= 1'b1;
            state_r  <= ST_HOLD;
            flag_r   <= 1'b1; // [R20]
            status_r <= rs_r ? `TWM_S_RSTART : `TWM_S_START; // [R7] [R8]
          end
        end
        ST_HOLD: begin
          cnt_r <= '0;
          if (flag_clr) begin
            if (status_r == `TWM_S_BUSERR || status_r == `TWM_S_ARB) begin
              state_r  <= ST_IDLE; // [R16] [R19]
              scl_oe_o <= 1'b0;
              sda_oe_o <= 1'b0;
            end else if (req_stop) begin
              state_r  <= ST_PLOW; // [R14] [R15]
              sda_oe_o <= 1'b1;
            end else if (req_start) begin
              state_r  <= ST_RLOW; // [R13]
              sda_oe_o <= 1'b0;
            end else begin
              state_r   <= ST_BLOW; // [R7] [R12]
              tx_r      <= data_r;
              bit_r     <= 4'h0;
              is_addr_r <= (status_r == `TWM_S_START) || (status_r == `TWM_S_RSTART);
            end
          end
        end
        ST_BLOW: begin
          scl_oe_o <= 1'b1; // [R1]
          if (scl_s) begin
            cnt_r <= '0; // [R2]
          end
          if (cnt_r == RATE_W'(1) && !scl_s) begin
            sda_oe_o <= ~lost_r & ~drive_val; // [R6]
          end
          if (half_end && !scl_s) begin
            scl_oe_o <= 1'b0;
            state_r  <= ST_BHIGH;
            cnt_r    <= '0;
          end
        end
        ST_BHIGH: begin
          if (!scl_s) begin
            cnt_r <= '0; // [R2]
          end
          if (berr) begin
            state_r  <= ST_HOLD; // [R19]
            flag_r   <= 1'b1;
            status_r <= `TWM_S_BUSERR;
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
          end else if (end_hi) begin
            cnt_r <= '0;
            if (bit_r < `TWM_ACK_BIT) begin
              if (drive_val && !sda_s) begin
                lost_r <= 1'b1; // [R3] [R4]
              end
              rx_r     <= {rx_r[6:0], sda_s};
              tx_r     <= {tx_r[6:0], 1'b0};
              bit_r    <= bit_r + 4'h1;
              state_r  <= ST_BLOW; // [R6]
              scl_oe_o <= 1'b1;
            end else begin
              state_r <= ST_HOLD;
              flag_r  <= 1'b1; // [R20]
              if (lost_r) begin
                status_r <= `TWM_S_ARB; // [R16]
                scl_oe_o <= 1'b0;
                addrd_r  <= is_addr_r && (rx_r[7:1] == own_r); // [R5]
              end else begin
                scl_oe_o <= 1'b1; // [R17]
                if (is_addr_r && rx_r[0]) begin
                  rxm_r    <= 1'b1; // [R8]
                  status_r <= sda_s ? `TWM_S_AR_NAK : `TWM_S_AR_ACK;
                end else if (is_addr_r) begin
                  status_r <= sda_s ? `TWM_S_AW_NAK : `TWM_S_AW_ACK; // [R10]
                end else begin
                  status_r <= sda_s ? `TWM_S_D_NAK : `TWM_S_D_ACK; // [R11]
                end
              end
            end
          end
        end
        ST_RLOW: begin
          if (half_end) begin
            scl_oe_o <= 1'b0;
            state_r  <= ST_RHIGH;
            cnt_r    <= '0;
          end
        end
        ST_RHIGH: begin
          if (!scl_s) begin
            cnt_r <= '0;
          end
          if (scl_s && half_end) begin
            sda_oe_o <= 1'b1; // [R9]
            rs_r     <= 1'b1;
            state_r  <= ST_START;
            cnt_r    <= '0;
          end
        end
        ST_PLOW: begin
          if (half_end) begin
            scl_oe_o <= 1'b0;
            state_r  <= ST_PHIGH;
            cnt_r    <= '0;
          end
        end
        ST_PHIGH: begin
          if (!scl_s) begin
            cnt_r <= '0;
          end
          if (scl_s && half_end) begin
            sda_oe_o <= 1'b0; // [R14]
            state_r  <= ST_PFREE;
            cnt_r    <= '0;
          end
        end
        ST_PFREE: begin
          // Start request still set here turns into STOP then START
          if (half_end) begin
            state_r <= ST_IDLE; // [R15]
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      if (!en_r) begin
        state_r  <= ST_IDLE;
        scl_oe_o <= 1'b0;
        sda_oe_o <= 1'b0;
      end
    end
  end

  // Open-drain: data value stays low, only enables move
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0; // [R1]
      sda_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_STAT_NONE: assert property ( // [R18]
    hit && !wb_req_i.we && wb_req_i.adr == `TWM_ADR_STAT && !flag_r
    |=> wb_dat_o[7:0] == `TWM_S_NONE)
    else $error("status not 0xF8 with flag clear");
  AST_HOLD_SCL: assert property ( // [R17]
    state_r == ST_HOLD && flag_r && en_r && status_r != `TWM_S_ARB &&
    status_r != `TWM_S_BUSERR |-> scl_oe_o)
    else $error("scl released while flag set");
  AST_LOST_SDA: assert property ( // [R6]
    lost_r && state_r == ST_BLOW && $past(state_r) == ST_BLOW |-> !sda_oe_o)
    else $error("sda driven after arbitration loss");
  AST_ARB_LOSS: assert property ( // [R3]
    en_r && state_r == ST_BHIGH && !berr && end_hi && bit_r < `TWM_ACK_BIT &&
    drive_val && !sda_s |=> lost_r)
    else $error("arbitration loss missed");
  AST_NO_LOSS: assert property ( // [R4]
    state_r == ST_BHIGH && end_hi && !drive_val && !lost_r |=> !lost_r)
    else $error("loss while driving low");
  AST_START_STAT: assert property ( // [R7]
    en_r && state_r == ST_START && half_end && !rs_r
    |=> flag_r && status_r == `TWM_S_START)
    else $error("start status wrong");
  AST_RSTART_STAT: assert property ( // [R8]
    en_r && state_r == ST_START && half_end && rs_r
    |=> flag_r && status_r == `TWM_S_RSTART)
    else $error("repeated start status wrong");
  AST_ADDR_ACK: assert property ( // [R10]
    en_r && state_r == ST_BHIGH && !berr && end_hi && bit_r == `TWM_ACK_BIT &&
    !lost_r && is_addr_r && !rx_r[0]
    |=> status_r == ($past(sda_s) ? `TWM_S_AW_NAK : `TWM_S_AW_ACK))
    else $error("address status wrong");
  AST_DATA_ACK: assert property ( // [R11]
    en_r && state_r == ST_BHIGH && !berr && end_hi && bit_r == `TWM_ACK_BIT &&
    !lost_r && !is_addr_r
    |=> status_r == ($past(sda_s) ? `TWM_S_D_NAK : `TWM_S_D_ACK))
    else $error("data status wrong");
  AST_LOW_RESTART: assert property ( // [R2]
    en_r && state_r == ST_BLOW && scl_s |=> cnt_r == '0)
    else $error("low count not restarted");
  AST_STOP_CLR: assert property ( // [R14]
    stop_done && !wr_ctrl |=> !stop_r)
    else $error("stop request not cleared");

endmodule : twm_master

// File: twm_bus_model.sv
`timescale 1ns/1ps

module twm_bus_model (
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic        ack_en_i,
  input  wire logic        lose_i,
  input  wire logic [15:0] stretch_i,
  output logic             scl_pull_o,
  output logic             sda_pull_o,
  output logic [7:0]       byte_o,
  output logic [7:0]       stops_o
);
  int         bits;
  logic [7:0] sh;

  initial begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
    byte_o     = 8'h00;
    stops_o    = 8'h00;
    bits       = -1;
    sh         = 8'h00;
  end

  // ----------------------------------------
  // Frame tracking on the wire
  // ----------------------------------------
  always @(negedge sda_i) begin
    if (scl_i === 1'b1) begin
      bits = -1;
    end
  end

  always @(posedge sda_i) begin
    if (scl_i === 1'b1) begin
      stops_o = stops_o + 8'h01;
    end
  end

  always @(posedge scl_i) begin
    if (bits >= 0 && bits < 8) begin
      sh = {sh[6:0], sda_i};
    end
  end

  // ----------------------------------------
  // Low phase: ack, rival master, stretch
  // ----------------------------------------
  always @(negedge scl_i) begin
    bits = (bits >= 8) ? 0 : bits + 1;
    if (bits == 8) begin
      byte_o = sh;
    end
    // Hold time after the fall before SDA moves
    #200;
    sda_pull_o = (bits == 8) ? ack_en_i : (lose_i && bits < 8);
    if (bits == 8 && stretch_i != 16'h0000) begin
      // Slow slave keeps the clock low over the ack
      scl_pull_o = 1'b1;
      #(stretch_i);
      scl_pull_o = 1'b0;
    end
  end
endmodule : twm_bus_model

// File: tb_two_wire_master_transmitter.sv
`timescale 1ns/1ps
`include "twm_consts.svh"

module tb_two_wire_master_transmitter
  import twm_pkg::*;
();
  localparam int RATE = 4;

  logic        clk_i      = 1'b0;
  logic        rst_i      = 1'b1;
  twm_wb_req_t req        = '0;
  logic        ack_en     = 1'b1;
  logic        lose       = 1'b0;
  logic [15:0] stretch    = 16'h0000;
  logic [31:0] wb_dat;
  logic        wb_ack;
  logic        scl_o;
  logic        scl_oe;
  logic        sda_o;
  logic        sda_oe;
  logic        scl_pull;
  logic        sda_pull;
  logic [7:0]  mbyte;
  logic [7:0]  stops;
  int          num_errors = 0;
  int          checks     = 0;
  int          hi_cnt     = 0;
  int          hi_min     = 1000;

  // Pull-ups: a released line reads high
  wire scl_w = !((scl_oe && !scl_o) || scl_pull);
  wire sda_w = !((sda_oe && !sda_o) || sda_pull);

  always #50 clk_i = ~clk_i;

  twm_master #(.RATE_W(8)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe)
  );

  twm_bus_model bus_u (
    .scl_i(scl_w), .sda_i(sda_w), .ack_en_i(ack_en), .lose_i(lose), .stretch_i(stretch),
    .scl_pull_o(scl_pull), .sda_pull_o(sda_pull), .byte_o(mbyte), .stops_o(stops)
  );

  // ----------------------------------------
  // Shortest SCL high time seen on the wire
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (scl_w === 1'b1) begin
      hi_cnt++;
    end else begin
      if (hi_cnt > 0 && hi_cnt < hi_min) hi_min = hi_cnt;
      hi_cnt = 0;
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // No own limit: only the watchdog may end a wait for ack
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    q = wb_dat;
    req <= '0;
    @(posedge clk_i);
  endtask : wb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask : rd

  // Write control, wait for the flag, compare status
  task step(input logic [7:0] c, input logic [7:0] exp);
    logic [31:0] q;
    int          n;
    n = 0;
    wr(`TWM_ADR_CTRL, {24'h0, c});
    do begin
      rd(`TWM_ADR_CTRL, q);
      n++;
    end while (q[7] !== 1'b1 && n < 400);
    rd(`TWM_ADR_STAT, q);
    chk(q, {24'h0, exp});
  endtask : step

  task send(input logic [7:0] d, input logic [7:0] exp);
    wr(`TWM_ADR_DATA, {24'h0, d});
    step(8'h84, exp);
  endtask : send

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_idle;
    logic [31:0] q;
    rd(`TWM_ADR_STAT, q);
    chk(q, {24'h0, `TWM_S_NONE});
    rd(8'h20, q);
    chk(q, 32'h0);
    rd(`TWM_ADR_CTRL, q);
    chk(q, 32'h0);
    wr(`TWM_ADR_RATE, RATE);
    rd(`TWM_ADR_RATE, q);
    chk(q, RATE);
  endtask : t_idle

  task t_frame;
    logic [31:0] q;
    logic [7:0]  n;
    int          m;
    step(8'h24, `TWM_S_START);
    repeat (40) @(posedge clk_i);
    chk(scl_oe, 1'b1);
    rd(`TWM_ADR_CTRL, q);
    chk(q[7], 1'b1);
    send(8'hA0, `TWM_S_AW_ACK);
    chk(mbyte, 8'hA0);
    stretch = 16'd3000;
    send(8'h5A, `TWM_S_D_ACK);
    chk(mbyte, 8'h5A);
    stretch = 16'h0000;
    ack_en  = 1'b0;
    send(8'h3C, `TWM_S_D_NAK);
    step(8'hA4, `TWM_S_RSTART);
    ack_en = 1'b1;
    send(8'hA2, `TWM_S_AW_ACK);
    chk(mbyte, 8'hA2);
    step(8'hA4, `TWM_S_RSTART);
    send(8'hA3, `TWM_S_AR_ACK);
    rd(`TWM_ADR_CTRL, q);
    chk(q[0], 1'b1);
    n = stops;
    step(8'hB4, `TWM_S_START);
    chk(stops, n + 8'h01);
    rd(`TWM_ADR_CTRL, q);
    chk(q[4], 1'b0);
    ack_en = 1'b0;
    send(8'hB0, `TWM_S_AW_NAK);
    wr(`TWM_ADR_CTRL, 32'h94);
    m = 0;
    do begin
      rd(`TWM_ADR_CTRL, q);
      m++;
    end while (q[4] !== 1'b0 && m < 400);
    repeat (20) @(posedge clk_i);
    chk(q[4], 1'b0);
    chk(stops, n + 8'h02);
    rd(`TWM_ADR_STAT, q);
    chk(q, {24'h0, `TWM_S_NONE});
    chk(hi_min >= RATE, 1);
  endtask : t_frame

  task t_arb;
    logic [31:0] q;
    ack_en = 1'b1;
    step(8'h24, `TWM_S_START);
    lose = 1'b1;
    // High bits match the rival; only the last bit loses
    send(8'h01, `TWM_S_ARB);
    chk(sda_oe, 1'b0);
    rd(`TWM_ADR_CTRL, q);
    chk(q[1], 1'b1);
    wr(`TWM_ADR_CTRL, 32'h84);
    lose = 1'b0;
    repeat (20) @(posedge clk_i);
    chk(scl_oe, 1'b0);
    chk(sda_oe, 1'b0);
  endtask : t_arb

  task results;
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_idle;
    t_frame;
    t_arb;
    results;
  end

  // Whole run is a few thousand cycles; this is far beyond it
  initial begin
    #(60000 * 100);
    num_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    results;
  end
endmodule : tb_two_wire_master_transmitter
